// ### hw/asf_cfg.svh
// Purpose: register indexes, field positions and fixed values
// Assumes: byte address of a register is four times its index
// Notes:   included by the fifo control block and the bench
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

`define ASF_IDX_TX_DATA 14'h2750
`define ASF_IDX_TX_PAT  14'h2751
`define ASF_IDX_TX_CTL  14'h2752
`define ASF_IDX_TX_RP   14'h2753
`define ASF_IDX_TX_WP   14'h2754
`define ASF_IDX_TX_STS  14'h275a
`define ASF_IDX_TX_SIZE 14'h275b
`define ASF_IDX_RX_DATA 14'h2760
`define ASF_IDX_RX_PAT  14'h2761
`define ASF_IDX_RX_CTL  14'h2762
`define ASF_IDX_IRQ_STS 14'h2780
`define ASF_IDX_IRQ_MSK 14'h2781

`define ASF_CTL_FILL 0
`define ASF_CTL_PRST 1
`define ASF_CTL_MUTE 2
`define ASF_CTL_DMA  3

`define ASF_STS_POP  2
`define ASF_STS_PUSH 3
`define ASF_STS_FILL 4

`define ASF_IRQ_OVF  0
`define ASF_IRQ_UNF  1
`define ASF_IRQ_DMA  2
`define ASF_IRQ_FILL 3

`define ASF_RESET_BYTE 8'h00
`define ASF_LAST_ENTRY 8'hff
`define ASF_PTR_STEP   9'h001
`define ASF_RESP_OKAY  2'h0
`define ASF_RESP_SLV   2'h2

`endif

// ### hw/asf_pkg.sv
// Purpose: types shared by the audio fifo control block
// Assumes: nothing beyond the cfg header
// Notes:   fill engine states are one-hot
package asf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_FILL_TX = 3'h2,
    ST_FILL_RX = 3'h4
  } asf_state_t;
  typedef logic [7:0] asf_byte_t;
endpackage

// ### hw/asf_fifo_ctrl.sv
// Purpose: transmit and receive byte fifos of the serial audio unit
// Assumes: one clock, AXI4-Lite master keeps one access of each kind
// Notes:   data port reads pop; pattern fill takes 256 cycles
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "asf_cfg.svh"

// What this block does
// R1: data port writes append, reads return bytes
// R2: silence bit substitutes pattern on transmit path
// R3: fill strobe writes pattern into every entry
// R4: pointer reset strobe zeroes pointers, clears errors
// R5: dma go strobe starts transfer, self clears
// R6: readable writable read pointer, wrap tracked
// R7: readable writable write pointer, wrap tracked
// R8: status bit four high during fill
// R9: status bit three shows push activity
// R10: status bit two shows pop activity
// R11: size register sets dma byte count
// R12: receive data port pushes and pops bytes
// R13: receive silence sends pattern; pattern resets zero
// R14: receive fill writes pattern into every entry
// R15: all registers reset to zero
// R16: serial audio input bytes enter transmit fifo
// R17: receive fifo bytes leave on serial output
// R18: overflow and underflow sticky until pointer reset or write-one clear
module asf_fifo_ctrl
  import asf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        audRxValid,
  input  wire logic [7:0]  audRxData,
  output logic             audRxReady,
  output logic             audTxValid,
  output logic [7:0]       audTxData,
  input  wire logic        audTxReady,
  output logic             macTxValid,
  output logic [7:0]       macTxData,
  input  wire logic        macTxReady,
  output logic             irq
);

  function automatic logic hit(input logic [15:0] a,
                               input logic [13:0] idx);
    hit = (a[1:0] == 2'h0) && (a[15:2] == idx);
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    mapped = 1'b0;
    if (a[1:0] == 2'h0) begin
      case (a[15:2])
        `ASF_IDX_TX_DATA, `ASF_IDX_TX_PAT, `ASF_IDX_TX_CTL,
        `ASF_IDX_TX_RP, `ASF_IDX_TX_WP, `ASF_IDX_TX_STS,
        `ASF_IDX_TX_SIZE, `ASF_IDX_RX_DATA, `ASF_IDX_RX_PAT,
        `ASF_IDX_RX_CTL, `ASF_IDX_IRQ_STS,
        `ASF_IDX_IRQ_MSK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  asf_byte_t  txMem [256];
  asf_byte_t  rxMem [256];
  asf_state_t state_q;

  logic        awHeld_q;
  logic [15:0] awAddr_q;
  logic        wHeld_q;
  logic [7:0]  wData_q;
  logic        wStrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdMux;

  asf_byte_t   txPat_q;
  asf_byte_t   rxPat_q;
  asf_byte_t   txSize_q;
  asf_byte_t   dmaLeft_q;
  logic        txMute_q;
  logic        rxMute_q;
  logic [7:0]  txRp_q;
  logic [7:0]  txWp_q;
  logic        txRpWrap_q;
  logic        txWpWrap_q;
  logic [8:0]  rxRp_q;
  logic [8:0]  rxWp_q;
  logic [7:0]  fillIdx_q;
  logic        fillTxReq_q;
  logic        fillRxReq_q;
  logic        pushSeen_q;
  logic        popSeen_q;
  logic [3:0]  irqSts_q;
  logic [3:0]  irqMsk_q;
  logic        macTxValid_q;
  asf_byte_t   macTxData_q;
  logic        audTxValid_q;
  asf_byte_t   audTxData_q;

  logic wrFire;
  logic wEn;
  logic rdFire;
  logic busy;
  logic txFull;
  logic txEmpty;
  logic rxFull;
  logic rxEmpty;
  logic swTxPush;
  logic audPush;
  logic txPushReq;
  logic txPush;
  logic swTxPop;
  logic dmaLoad;
  logic txPop;
  logic rxPush;
  logic rxSwPop;
  logic rxOutPop;
  logic rxOutLoad;
  logic txPrst;
  logic rxPrst;
  logic txCtlWr;
  logic rxCtlWr;
  logic fillLast;
  logic [3:0] irqEv;

  // bus handshake
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h00_0000, rdata_q};

  assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
  assign wEn    = wrFire && wStrb_q;
  assign rdFire = s_axi_arvalid && !rvalid_q;
  assign busy   = (state_q != ST_IDLE);

  assign txCtlWr = wEn && hit(awAddr_q, `ASF_IDX_TX_CTL);
  assign rxCtlWr = wEn && hit(awAddr_q, `ASF_IDX_RX_CTL);
  assign txPrst  = txCtlWr && wData_q[`ASF_CTL_PRST];
  assign rxPrst  = rxCtlWr && wData_q[`ASF_CTL_PRST];

  // full when indexes meet with opposite wrap
  assign txEmpty = (txRp_q == txWp_q) && (txRpWrap_q == txWpWrap_q);
  assign txFull  = (txRp_q == txWp_q) && (txRpWrap_q != txWpWrap_q);
  assign rxEmpty = (rxRp_q == rxWp_q);
  assign rxFull  = (rxRp_q == {~rxWp_q[8], rxWp_q[7:0]});

  // R1: software push
  assign swTxPush  = wEn && hit(awAddr_q, `ASF_IDX_TX_DATA) && !busy;
  // R16: serial input yields to software
  assign audRxReady = !busy && !swTxPush;
  assign audPush   = audRxValid && audRxReady;
  assign txPushReq = swTxPush || audPush;
  assign txPush    = txPushReq && !txFull;
  assign swTxPop   = rdFire && hit(s_axi_araddr, `ASF_IDX_TX_DATA) && !busy;
  // R5: dma drains one byte when output slot free
  assign dmaLoad = (dmaLeft_q != `ASF_RESET_BYTE) && !busy && !txEmpty &&
                   !swTxPop && (!macTxValid_q || macTxReady);
  assign txPop   = (swTxPop && !txEmpty) || dmaLoad;

  // R12: receive data port
  assign rxPush  = wEn && hit(awAddr_q, `ASF_IDX_RX_DATA) && !busy &&
                   !rxFull;
  assign rxSwPop = rdFire && hit(s_axi_araddr, `ASF_IDX_RX_DATA) &&
                   !busy && !rxEmpty;
  // R17: serial output takes a byte when its slot frees
  assign rxOutLoad = !audTxValid_q || audTxReady;
  assign rxOutPop  = rxOutLoad && !rxMute_q && !busy && !rxEmpty &&
                     !rxSwPop;

  assign fillLast = (fillIdx_q == `ASF_LAST_ENTRY);

  // R18: overflow and underflow events, plus dma done and transmit fill done
  always_comb begin
    irqEv = 4'h0;
    irqEv[`ASF_IRQ_OVF]  = txPushReq && txFull;
    irqEv[`ASF_IRQ_UNF]  = swTxPop && txEmpty;
    irqEv[`ASF_IRQ_DMA]  = dmaLoad && (dmaLeft_q == 8'h01);
    irqEv[`ASF_IRQ_FILL] = (state_q == ST_FILL_TX) && fillLast;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 16'h0000;
      wHeld_q  <= 1'b0;
      wData_q  <= `ASF_RESET_BYTE;
      wStrb_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `ASF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata[7:0];
        wStrb_q <= s_axi_wstrb[0];
      end else if (wrFire) begin
        wHeld_q <= 1'b0;
      end
      if (wrFire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= mapped(awAddr_q) ? `ASF_RESP_OKAY : `ASF_RESP_SLV;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rdMux = `ASF_RESET_BYTE;
    case (s_axi_araddr[15:2])
      `ASF_IDX_TX_DATA: rdMux = txEmpty ? `ASF_RESET_BYTE : txMem[txRp_q];
      `ASF_IDX_TX_PAT:  rdMux = txPat_q;
      // R2: silence bit readable, strobes read zero
      `ASF_IDX_TX_CTL:  rdMux = {5'h00, txMute_q, 2'h0};
      `ASF_IDX_TX_RP:   rdMux = txRp_q;
      `ASF_IDX_TX_WP:   rdMux = txWp_q;
      // R8: fill, R9: push, R10: pop, others zero
      `ASF_IDX_TX_STS:  rdMux = {3'h0, state_q == ST_FILL_TX,
                                 pushSeen_q, popSeen_q, 2'h0};
      `ASF_IDX_TX_SIZE: rdMux = txSize_q;
      `ASF_IDX_RX_DATA: rdMux = rxEmpty ? `ASF_RESET_BYTE
                                        : rxMem[rxRp_q[7:0]];
      `ASF_IDX_RX_PAT:  rdMux = rxPat_q;
      `ASF_IDX_RX_CTL:  rdMux = {5'h00, rxMute_q, 2'h0};
      `ASF_IDX_IRQ_STS: rdMux = {4'h0, irqSts_q};
      `ASF_IDX_IRQ_MSK: rdMux = {4'h0, irqMsk_q};
      default:          rdMux = `ASF_RESET_BYTE;
    endcase
    if (s_axi_araddr[1:0] != 2'h0) begin
      rdMux = `ASF_RESET_BYTE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `ASF_RESP_OKAY;
      rdata_q  <= `ASF_RESET_BYTE;
    end else if (rdFire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(s_axi_araddr) ? `ASF_RESP_OKAY : `ASF_RESP_SLV;
      rdata_q  <= rdMux;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // R15: plain registers start at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txPat_q  <= `ASF_RESET_BYTE;
      rxPat_q  <= `ASF_RESET_BYTE;
      txSize_q <= `ASF_RESET_BYTE;
      txMute_q <= 1'b0;
      rxMute_q <= 1'b0;
      irqMsk_q <= 4'h0;
    end else if (wEn) begin
      if (hit(awAddr_q, `ASF_IDX_TX_PAT))
        txPat_q <= wData_q;
      // R13: receive pattern
      if (hit(awAddr_q, `ASF_IDX_RX_PAT))
        rxPat_q <= wData_q;
      // R11: dma size
      if (hit(awAddr_q, `ASF_IDX_TX_SIZE))
        txSize_q <= wData_q;
      // R2: silence enable
      if (txCtlWr)
        txMute_q <= wData_q[`ASF_CTL_MUTE];
      if (rxCtlWr)
        rxMute_q <= wData_q[`ASF_CTL_MUTE];
      if (hit(awAddr_q, `ASF_IDX_IRQ_MSK))
        irqMsk_q <= wData_q[3:0];
    end
  end

  // R4: pointer reset strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txRp_q     <= `ASF_RESET_BYTE;
      txWp_q     <= `ASF_RESET_BYTE;
      txRpWrap_q <= 1'b0;
      txWpWrap_q <= 1'b0;
    end else if (txPrst) begin
      txRp_q     <= `ASF_RESET_BYTE;
      txWp_q     <= `ASF_RESET_BYTE;
      txRpWrap_q <= 1'b0;
      txWpWrap_q <= 1'b0;
    end else begin
      // R6: read pointer, wrap bit carried beside it
      if (wEn && hit(awAddr_q, `ASF_IDX_TX_RP))
        txRp_q <= wData_q;
      else if (txPop)
        {txRpWrap_q, txRp_q} <= {txRpWrap_q, txRp_q} + `ASF_PTR_STEP;
      // R7: write pointer
      if (wEn && hit(awAddr_q, `ASF_IDX_TX_WP))
        txWp_q <= wData_q;
      else if (txPush)
        {txWpWrap_q, txWp_q} <= {txWpWrap_q, txWp_q} + `ASF_PTR_STEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxRp_q <= 9'h000;
      rxWp_q <= 9'h000;
    end else if (rxPrst) begin
      rxRp_q <= 9'h000;
      rxWp_q <= 9'h000;
    end else begin
      if (rxSwPop || rxOutPop)
        rxRp_q <= rxRp_q + `ASF_PTR_STEP;
      if (rxPush)
        rxWp_q <= rxWp_q + `ASF_PTR_STEP;
    end
  end

  // storage has no reset; the fill strobe clears it in software's hands
  always_ff @(posedge sys_clk) begin
    // R3: pattern fill of every entry
    if (state_q == ST_FILL_TX)
      txMem[fillIdx_q] <= txPat_q;
    else if (txPush)
      txMem[txWp_q] <= swTxPush ? wData_q : audRxData;
  end

  always_ff @(posedge sys_clk) begin
    // R14: receive pattern fill
    if (state_q == ST_FILL_RX)
      rxMem[fillIdx_q] <= rxPat_q;
    else if (rxPush)
      rxMem[rxWp_q[7:0]] <= wData_q;
  end

  // fill requests wait while the other fifo is being filled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fillTxReq_q <= 1'b0;
      fillRxReq_q <= 1'b0;
    end else begin
      fillTxReq_q <= (fillTxReq_q && state_q != ST_FILL_TX) ||
                     (txCtlWr && wData_q[`ASF_CTL_FILL]);
      fillRxReq_q <= (fillRxReq_q && state_q != ST_FILL_RX) ||
                     (rxCtlWr && wData_q[`ASF_CTL_FILL]);
    end
  end

  // R8: fill engine, one entry a cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      fillIdx_q <= `ASF_RESET_BYTE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          fillIdx_q <= `ASF_RESET_BYTE;
          if (fillTxReq_q)
            state_q <= ST_FILL_TX;
          else if (fillRxReq_q)
            state_q <= ST_FILL_RX;
        end
        ST_FILL_TX, ST_FILL_RX: begin
          fillIdx_q <= fillIdx_q + 8'h01;
          if (fillLast)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // R9: push seen, R10: pop seen or dma running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pushSeen_q <= 1'b0;
      popSeen_q  <= 1'b0;
    end else begin
      pushSeen_q <= txPush;
      popSeen_q  <= txPop || (dmaLeft_q != `ASF_RESET_BYTE);
    end
  end

  // R5: go strobe loads the count and is never stored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dmaLeft_q    <= `ASF_RESET_BYTE;
      macTxValid_q <= 1'b0;
      macTxData_q  <= `ASF_RESET_BYTE;
    end else begin
      if (txCtlWr && wData_q[`ASF_CTL_DMA])
        dmaLeft_q <= txSize_q;
      else if (dmaLoad)
        dmaLeft_q <= dmaLeft_q - 8'h01;
      if (dmaLoad) begin
        macTxValid_q <= 1'b1;
        // R2: substitute still consumes the stored byte
        macTxData_q  <= txMute_q ? txPat_q : txMem[txRp_q];
      end else if (macTxReady) begin
        macTxValid_q <= 1'b0;
      end
    end
  end

  // R13: muted output repeats the pattern without popping
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audTxValid_q <= 1'b0;
      audTxData_q  <= `ASF_RESET_BYTE;
    end else if (rxOutLoad) begin
      if (rxMute_q) begin
        audTxValid_q <= 1'b1;
        audTxData_q  <= rxPat_q;
      end else if (rxOutPop) begin
        audTxValid_q <= 1'b1;
        audTxData_q  <= rxMem[rxRp_q[7:0]];
      end else begin
        audTxValid_q <= 1'b0;
      end
    end
  end

  // R18: sticky flags; set beats write-one clear and pointer reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqSts_q <= 4'h0;
    end else begin
      irqSts_q <= (irqSts_q &
                   ~((wEn && hit(awAddr_q, `ASF_IDX_IRQ_STS)) ?
                     wData_q[3:0] : 4'h0) &
                   ~(txPrst ? 4'h3 : 4'h0)) | irqEv;
    end
  end

  assign irq        = |(irqSts_q & irqMsk_q);
  assign macTxValid = macTxValid_q;
  assign macTxData  = macTxData_q;
  assign audTxValid = audTxValid_q;
  assign audTxData  = audTxData_q;

endmodule

// ### bench/asf_fifo_checker.sv
// Purpose: handshake assertions at the ports of the fifo control block
// Assumes: one clock domain, reset active high
// Notes:   register contents are judged by the bench
`timescale 1ns/100ps
module asf_fifo_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        audTxValid,
  input wire logic [7:0]  audTxData,
  input wire logic        audTxReady,
  input wire logic        macTxValid,
  input wire logic [7:0]  macTxData,
  input wire logic        macTxReady,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_aw_refused: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  a_w_refused: assert property (
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("data taken twice");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_mac_holds: assert property (
    macTxValid && !macTxReady |=> macTxValid && $stable(macTxData))
    else $error("mac byte dropped");
  a_aud_holds: assert property (
    audTxValid && !audTxReady |=> audTxValid && $stable(audTxData))
    else $error("audio byte dropped");

  cover property (macTxValid && macTxReady);
  cover property (audTxValid && audTxReady);
  cover property (irq);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind asf_fifo_ctrl asf_fifo_checker chk_i (.sys_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .audTxValid, .audTxData, .audTxReady,
  .macTxValid, .macTxData, .macTxReady, .irq);

// ### bench/asf_far_model.sv
// Purpose: far side of the fifo block: mac fifo sink and audio consumer
// Assumes: a byte moves on valid and ready at a rising edge
// Notes:   slow halves the mac acceptance rate
`timescale 1ns/100ps
module asf_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       macTxValid,
  input  wire logic [7:0] macTxData,
  output logic            macTxReady,
  input  wire logic       audTxValid,
  input  wire logic [7:0] audTxData,
  output logic            audTxReady
);
  logic [7:0] macQ [$];
  logic [7:0] audQ [$];
  logic       tgl_q;

  // toggling ready forces the block to hold bytes across refusals
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tgl_q      <= 1'b0;
      macTxReady <= 1'b0;
      audTxReady <= 1'b0;
    end else begin
      tgl_q      <= ~tgl_q;
      macTxReady <= slow ? tgl_q : 1'b1;
      audTxReady <= tgl_q;
      if (macTxValid && macTxReady) macQ.push_back(macTxData);
      if (audTxValid && audTxReady) audQ.push_back(audTxData);
    end
  end
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench for the audio fifo control block
// Assumes: byte address is four times the register index
// Notes:   long waits poll status or queues under a bound
`timescale 1ns/100ps
`include "asf_cfg.svh"
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        audRxValid = 1'b0;
  logic [7:0]  audRxData = 8'h00;
  logic        slow = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, audRxReady, audTxValid, audTxReady;
  logic        macTxValid, macTxReady, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic [7:0]  audTxData, macTxData, rdv;
  int          errors = 0;
  int          comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  asf_fifo_ctrl uut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .audRxValid, .audRxData,
    .audRxReady, .audTxValid, .audTxData, .audTxReady, .macTxValid,
    .macTxData, .macTxReady, .irq);

  asf_far_model far (.sys_clk, .rst, .slow, .macTxValid, .macTxData,
    .macTxReady, .audTxValid, .audTxData, .audTxReady);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= 32'(d);
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [13:0] idx);
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rdv, e);
  endtask

  task automatic aud(input logic [7:0] d);
    @(posedge sys_clk);
    audRxValid <= 1'b1;
    audRxData <= d;
    do @(posedge sys_clk); while (!audRxReady);
    audRxValid <= 1'b0;
    audRxData <= ~d;
  endtask

  task automatic waitq(input bit mac, input int k);
    int n;
    n = 0;
    while ((mac ? far.macQ.size() : far.audQ.size()) < k && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic t_reset;
    rdc(`ASF_IDX_TX_PAT, 8'h00);
    rdc(`ASF_IDX_TX_CTL, 8'h00);
    rdc(`ASF_IDX_TX_RP, 8'h00);
    rdc(`ASF_IDX_TX_WP, 8'h00);
    rdc(`ASF_IDX_TX_STS, 8'h00);
    rdc(`ASF_IDX_TX_SIZE, 8'h00);
    rdc(`ASF_IDX_RX_PAT, 8'h00);
    wr(14'h2755, 8'hff);
    chk(8'(rsp), 8'h02);
    rdc(14'h2755, 8'h00);
    chk(8'(rsp), 8'h02);
  endtask

  task automatic t_fill;
    int n;
    wr(`ASF_IDX_TX_PAT, 8'h5a);
    wr(`ASF_IDX_TX_CTL, 8'h01);
    rdc(`ASF_IDX_TX_STS, 8'h10);
    chk(8'(audRxReady), 8'h00);
    n = 0;
    do begin
      rd(`ASF_IDX_TX_STS);
      n++;
    end while (rdv[4] && n < 200);
    chk(rdv, 8'h00);
    chk(8'(audRxReady), 8'h01);
    wr(`ASF_IDX_TX_WP, 8'h02);
    rdc(`ASF_IDX_TX_DATA, 8'h5a);
    rdc(`ASF_IDX_TX_DATA, 8'h5a);
    rdc(`ASF_IDX_TX_CTL, 8'h00);
  endtask

  task automatic t_order;
    wr(`ASF_IDX_TX_CTL, 8'h02);
    rdc(`ASF_IDX_TX_RP, 8'h00);
    rdc(`ASF_IDX_TX_WP, 8'h00);
    for (int i = 1; i < 4; i++) wr(`ASF_IDX_TX_DATA, 8'(i * 17));
    rdc(`ASF_IDX_TX_WP, 8'h03);
    rdc(`ASF_IDX_TX_DATA, 8'h11);
    rdc(`ASF_IDX_TX_RP, 8'h01);
    wr(`ASF_IDX_TX_RP, 8'h02);
    rdc(`ASF_IDX_TX_DATA, 8'h33);
  endtask

  task automatic t_errors;
    rdc(`ASF_IDX_TX_DATA, 8'h00);
    rd(`ASF_IDX_IRQ_STS);
    chk(rdv & 8'h03, 8'h02);
    chk(8'(irq), 8'h00);
    wr(`ASF_IDX_IRQ_MSK, 8'h02);
    chk(8'(irq), 8'h01);
    wr(`ASF_IDX_TX_CTL, 8'h02);
    rd(`ASF_IDX_IRQ_STS);
    chk(rdv & 8'h03, 8'h00);
    chk(8'(irq), 8'h00);
    wr(`ASF_IDX_IRQ_MSK, 8'h00);
    wr(`ASF_IDX_IRQ_STS, 8'hff);
    rdc(`ASF_IDX_IRQ_STS, 8'h00);
  endtask

  // 256 bytes fill the buffer, the 257th is accepted on the port but dropped
  task automatic t_over;
    for (int i = 0; i < 257; i++) aud(8'(i));
    rd(`ASF_IDX_IRQ_STS);
    chk(rdv & 8'h01, 8'h01);
    rdc(`ASF_IDX_TX_DATA, 8'h00);
    rdc(`ASF_IDX_TX_DATA, 8'h01);
  endtask

  task automatic t_dma;
    wr(`ASF_IDX_TX_CTL, 8'h02);
    slow <= 1'b1;
    for (int i = 1; i < 3; i++) wr(`ASF_IDX_TX_DATA, 8'(8'ha0 + i));
    // status read lands in the cycle right after the push executes
    fork
      wr(`ASF_IDX_TX_DATA, 8'ha3);
      begin
        repeat (2) @(posedge sys_clk);
        rd(`ASF_IDX_TX_STS);
      end
    join
    chk(rdv, 8'h08);
    wr(`ASF_IDX_TX_SIZE, 8'h02);
    rdc(`ASF_IDX_TX_SIZE, 8'h02);
    wr(`ASF_IDX_TX_CTL, 8'h08);
    rdc(`ASF_IDX_TX_CTL, 8'h00);
    waitq(1'b1, 2);
    chk(far.macQ[0], 8'ha1);
    chk(far.macQ[1], 8'ha2);
    wr(`ASF_IDX_TX_PAT, 8'h77);
    wr(`ASF_IDX_TX_CTL, 8'h04);
    rdc(`ASF_IDX_TX_CTL, 8'h04);
    wr(`ASF_IDX_TX_SIZE, 8'h01);
    wr(`ASF_IDX_TX_CTL, 8'h0c);
    waitq(1'b1, 3);
    chk(far.macQ[2], 8'h77);
    rdc(`ASF_IDX_TX_RP, 8'h03);
    // go on an empty fifo leaves the count pending, so pop stays shown
    wr(`ASF_IDX_TX_CTL, 8'h08);
    rdc(`ASF_IDX_TX_STS, 8'h04);
  endtask

  task automatic t_rx;
    int n;
    wr(`ASF_IDX_RX_DATA, 8'h3c);
    wr(`ASF_IDX_RX_DATA, 8'h4d);
    waitq(1'b0, 2);
    chk(far.audQ[0], 8'h3c);
    chk(far.audQ[1], 8'h4d);
    wr(`ASF_IDX_RX_PAT, 8'h99);
    wr(`ASF_IDX_RX_CTL, 8'h04);
    n = far.audQ.size();
    waitq(1'b0, n + 3);
    chk(far.audQ[far.audQ.size() - 1], 8'h99);
    wr(`ASF_IDX_RX_DATA, 8'h5e);
    rdc(`ASF_IDX_RX_DATA, 8'h5e);
    wr(`ASF_IDX_RX_CTL, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_fill();
    t_order();
    t_errors();
    t_over();
    t_dma();
    t_rx();
    test_done();
  end

  // the whole run needs between one and two thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule
